/* File: src/sap_pkg.sv */
// package: register map, field layout, codes and carrier types of the slave audio port
package sap_pkg;

  localparam logic [7:0]  SAP_REG_CTRL      = 8'h00;
  localparam logic [7:0]  SAP_REG_OUTCFG    = 8'h04;
  localparam logic [7:0]  SAP_REG_TXDATA    = 8'h08;
  localparam logic [7:0]  SAP_REG_RXDATA    = 8'h0c;
  localparam logic [7:0]  SAP_REG_STATUS    = 8'h10;

  localparam int          SAP_FMT_LSB       = 0;
  localparam int          SAP_WIDTH_LSB     = 2;
  localparam int          SAP_RATE_LSB      = 4;
  localparam int          SAP_RATIO_LSB     = 8;
  localparam int          SAP_ATTEN_BIT     = 10;
  localparam int          SAP_SOURCE_CHANNEL_SELECT_LSB     = 11;
  localparam int          SAP_CTRL_W        = 13;
  localparam int          SAP_OUT_EN_BIT    = 0;
  localparam int          SAP_OUT_SLOT_BIT  = 1;
  localparam int          SAP_OUT_HZ_BIT    = 2;
  localparam int          SAP_OUTCFG_W      = 3;
  localparam int          SAP_ST_BUSY_BIT   = 0;
  localparam int          SAP_ST_RATIO_BIT  = 1;
  localparam int          SAP_ST_RATE_BIT   = 2;

  localparam logic [12:0] SAP_CTRL_RST      = 13'h0280;
  localparam logic [2:0]  SAP_OUTCFG_RST    = 3'h0;
  localparam logic [3:0]  SAP_RATE_LAST     = 4'h8;

  localparam logic [5:0]  SAP_BITS_16       = 6'h10;
  localparam logic [5:0]  SAP_BITS_20       = 6'h14;
  localparam logic [5:0]  SAP_BITS_24       = 6'h18;
  localparam logic [5:0]  SAP_BITS_32       = 6'h20;

  typedef enum logic [1:0] {
    SAP_FMT_STD = 2'h0,
    SAP_FMT_LJ  = 2'h1,
    SAP_FMT_RJ  = 2'h3
  } sap_format_t;

  typedef enum logic [1:0] {
    SAP_WIDTH_16 = 2'h0,
    SAP_WIDTH_20 = 2'h1,
    SAP_WIDTH_24 = 2'h2,
    SAP_WIDTH_32 = 2'h3
  } sap_width_t;

  typedef enum logic [1:0] {
    SAP_RATIO_32 = 2'h0,
    SAP_RATIO_48 = 2'h1,
    SAP_RATIO_64 = 2'h2
  } sap_ratio_t;

  typedef enum logic [1:0] {
    SAP_CH_LEFT  = 2'h0,
    SAP_CH_RIGHT = 2'h1,
    SAP_CH_AVG   = 2'h2
  } sap_source_channel_select_t;

  typedef struct packed {
    sap_source_channel_select_t  source_channel_select;
    logic        atten;
    sap_ratio_t  ratio;
    logic [3:0]  rate;
    sap_width_t  width;
    sap_format_t format;
  } sap_port_cfg_t;

  typedef struct packed {
    logic highz;
    logic slot;
    logic enable;
  } sap_out_cfg_t;

  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } sap_sample_t;

endpackage

/* File: src/sap_top.sv */
// slave serial audio port: register port, bit-clock side receiver and transmitter, mixer
// Operation
// RQ1: device is slave only; bit clock and word select are inputs, never driven.
// RQ2: standard, left- and right-justified framing by mode field, always MSB first.
// RQ3: width field picks 16, 20, 24 or 32 data bits per slot.
// RQ4: rate field selects one of nine sample rates; host toggles word select per frame.
// RQ5: ratio field selects 32, 48 or 64 bit clocks per stereo frame.
// RQ6: host uses 32x ratio only with 16-bit words.
// RQ7: incoming word select and bit clock time the port; rate equals word-select rate.
// RQ8: input-level bit passes audio unchanged or attenuated by 6 dB.
// RQ9: channel select picks left, right or average of left and right.
// RQ10: output enable gates data out; slot select; other slot zeros or high impedance.
// RQ11: with output disabled both slots are zeros or high impedance per select bit.
// RQ12: standard format: word select low is left slot, high is right.
// RQ13: standard format: MSB valid on second rising bit-clock edge after transition.
// RQ14: left-justified: word select high is left slot, low is right.
// RQ15: left-justified: MSB valid on first rising bit-clock edge after transition.
// RQ16: right-justified: word select high is left slot, low is right.
// RQ17: right-justified: bit 0 valid on rising edge just before word-select change.
// RQ18: sample inputs on rising bit-clock edges, launch output on falling edges.
// RQ19: bits beyond word length ignored on input, driven as zeros on output.
module sap_top (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  input  wire logic                 link_bclk,
  input  wire logic                 word_select_line,
  input  wire logic                 serial_audio_in,
  output logic                      serial_audio_out,
  output logic                      serial_audio_out_oe,
  output sap_pkg::sap_sample_t      audio_sample,
  output logic [3:0]                sample_rate_code
);
  import sap_pkg::*;

  function automatic logic [5:0] word_bits(input sap_width_t w);
    case (w)
      SAP_WIDTH_16: word_bits = SAP_BITS_16;
      SAP_WIDTH_20: word_bits = SAP_BITS_20;
      SAP_WIDTH_24: word_bits = SAP_BITS_24;
      default:      word_bits = SAP_BITS_32;
    endcase
  endfunction

  function automatic logic [5:0] slot_bits(input sap_ratio_t r);
    case (r)
      SAP_RATIO_32: slot_bits = SAP_BITS_16;
      SAP_RATIO_48: slot_bits = SAP_BITS_24;
      default:      slot_bits = SAP_BITS_32;
    endcase
  endfunction

  function automatic logic in_window(input logic [5:0] pos, input logic [5:0] off,
                                     input logic [5:0] bits);
    in_window = (pos >= off) && ({1'b0, pos} < ({1'b0, off} + {1'b0, bits}));
  endfunction

  function automatic logic [31:0] mix(input sap_source_channel_select_t sel, input logic atten,
                                      input logic [31:0] l, input logic [31:0] r);
    logic signed [32:0] acc;
    acc = 33'h0;
    case (sel)
      SAP_CH_LEFT:  acc = {l[31], l};
      SAP_CH_RIGHT: acc = {r[31], r};
      // sum made signed so the halving keeps the sign bit
      default:      acc = $signed({l[31], l} + {r[31], r}) >>> 1;
    endcase
    if (atten) begin
      acc = acc >>> 1;
    end
    mix = acc[31:0];
  endfunction

  // ---------------- system clock side ----------------
  sap_port_cfg_t ctrl_reg;
  sap_out_cfg_t  ocfg_reg;
  logic [31:0]   tx_data_reg, tx_hold_reg, rdata_reg;
  logic          tx_dirty_reg, tx_req_reg, ack_s1_reg, ack_s2_reg;
  logic          frm_s1_reg, frm_s2_reg, frm_s3_reg;
  sap_sample_t   sample_reg;
  logic          new_frame, tx_busy, ratio_bad, rate_bad;

  // ---------------- bit clock side ----------------
  logic          brst_s1_reg, brst_n;
  logic [15:0]   cfg_s1_reg, cfg_s2_reg;
  sap_port_cfg_t b_ctrl;
  sap_out_cfg_t  b_ocfg;
  logic          ws_dly_reg, eff_prev_reg, chan_left_reg, frm_tgl_reg;
  logic [5:0]    pos_reg;
  logic [31:0]   shift_reg, left_reg, right_reg, tx_word_reg;
  logic          req_s1_reg, req_s2_reg, ack_b_reg, sao_reg, sao_oe_reg;
  logic          is_std, is_rj, ws_eff, ws_edge, left_now, left_prev, in_win;
  logic [5:0]    wbits, sbits, off, pos_now, q_next, tx_idx;
  logic          ch_left_next, slot_match, out_win;

  // register writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= sap_port_cfg_t'(SAP_CTRL_RST);
      ocfg_reg <= sap_out_cfg_t'(SAP_OUTCFG_RST);
    end else if (reg_wr) begin
      if (reg_addr == SAP_REG_CTRL) begin
        ctrl_reg.format <= sap_format_t'(reg_wdata[SAP_FMT_LSB +: 2]);   // [RQ2]
        ctrl_reg.width  <= sap_width_t'(reg_wdata[SAP_WIDTH_LSB +: 2]);  // [RQ3]
        ctrl_reg.rate   <= reg_wdata[SAP_RATE_LSB +: 4];                 // [RQ4]
        ctrl_reg.ratio  <= sap_ratio_t'(reg_wdata[SAP_RATIO_LSB +: 2]);  // [RQ5]
        ctrl_reg.atten  <= reg_wdata[SAP_ATTEN_BIT];                     // [RQ8]
        ctrl_reg.source_channel_select  <= sap_source_channel_select_t'(reg_wdata[SAP_SOURCE_CHANNEL_SELECT_LSB +: 2]);  // [RQ9]
      end else if (reg_addr == SAP_REG_OUTCFG) begin
        ocfg_reg.enable <= reg_wdata[SAP_OUT_EN_BIT];                    // [RQ10]
        ocfg_reg.slot   <= reg_wdata[SAP_OUT_SLOT_BIT];
        ocfg_reg.highz  <= reg_wdata[SAP_OUT_HZ_BIT];                    // [RQ11]
      end
    end
  end

  // transmit word handoff; a new write wins over the handoff clearing dirty
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_data_reg  <= 32'h0;
      tx_hold_reg  <= 32'h0;
      tx_dirty_reg <= 1'b0;
      tx_req_reg   <= 1'b0;
    end else if (reg_wr && reg_addr == SAP_REG_TXDATA) begin
      tx_data_reg  <= reg_wdata;
      tx_dirty_reg <= 1'b1;
    end else if (tx_dirty_reg && (tx_req_reg == ack_s2_reg)) begin
      tx_hold_reg  <= tx_data_reg;
      tx_req_reg   <= ~tx_req_reg;
      tx_dirty_reg <= 1'b0;
    end
  end

  // crossings into the system clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      frm_s1_reg <= 1'b0;
      frm_s2_reg <= 1'b0;
      frm_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_b_reg;
      ack_s2_reg <= ack_s1_reg;
      frm_s1_reg <= frm_tgl_reg;
      frm_s2_reg <= frm_s1_reg;
      frm_s3_reg <= frm_s2_reg;
    end
  end

  assign new_frame = frm_s2_reg ^ frm_s3_reg;

  // left/right words hold for a whole slot after the toggle, so reading them here is safe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sample_reg <= '0;
    end else begin
      sample_reg.valid <= new_frame;                                     // [RQ7]
      if (new_frame) begin
        sample_reg.data <= mix(ctrl_reg.source_channel_select, ctrl_reg.atten, left_reg, right_reg); // [RQ8] [RQ9]
      end
    end
  end

  assign tx_busy   = tx_dirty_reg | (tx_req_reg != ack_s2_reg);
  assign ratio_bad = (ctrl_reg.ratio == SAP_RATIO_32 && ctrl_reg.width != SAP_WIDTH_16) ||
                     (ctrl_reg.ratio != SAP_RATIO_32 && ctrl_reg.ratio != SAP_RATIO_48 &&
                      ctrl_reg.ratio != SAP_RATIO_64);                   // [RQ6]
  assign rate_bad  = ctrl_reg.rate > SAP_RATE_LAST;                      // [RQ4]

  // register reads; data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= 32'h0;
      if (reg_rd) begin
        if (reg_addr == SAP_REG_CTRL) begin
          rdata_reg <= {{(32 - SAP_CTRL_W){1'b0}}, ctrl_reg};
        end else if (reg_addr == SAP_REG_OUTCFG) begin
          rdata_reg <= {{(32 - SAP_OUTCFG_W){1'b0}}, ocfg_reg};
        end else if (reg_addr == SAP_REG_TXDATA) begin
          rdata_reg <= tx_data_reg;
        end else if (reg_addr == SAP_REG_RXDATA) begin
          rdata_reg <= sample_reg.data;
        end else if (reg_addr == SAP_REG_STATUS) begin
          rdata_reg[SAP_ST_BUSY_BIT]  <= tx_busy;
          rdata_reg[SAP_ST_RATIO_BIT] <= ratio_bad;
          rdata_reg[SAP_ST_RATE_BIT]  <= rate_bad;
        end
      end
    end
  end

  assign reg_rdata        = rdata_reg;
  assign audio_sample     = sample_reg;
  assign sample_rate_code = ctrl_reg.rate;                               // [RQ4]

  // ---------------- bit clock domain ----------------
  // reset released in step with the bit clock; the clock may stop between streams
  always_ff @(posedge link_bclk or negedge resetn) begin
    if (!resetn) begin
      brst_s1_reg <= 1'b0;
      brst_n      <= 1'b0;
    end else begin
      brst_s1_reg <= 1'b1;
      brst_n      <= brst_s1_reg;
    end
  end

  // configuration is quasi-static; change it only while the link is idle
  always_ff @(posedge link_bclk or negedge brst_n) begin
    if (!brst_n) begin
      cfg_s1_reg <= {SAP_OUTCFG_RST, SAP_CTRL_RST};
      cfg_s2_reg <= {SAP_OUTCFG_RST, SAP_CTRL_RST};
    end else begin
      cfg_s1_reg <= {ocfg_reg, ctrl_reg};
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  assign b_ctrl = sap_port_cfg_t'(cfg_s2_reg[SAP_CTRL_W-1:0]);
  assign b_ocfg = sap_out_cfg_t'(cfg_s2_reg[15:SAP_CTRL_W]);

  always_comb begin
    is_std    = (b_ctrl.format != SAP_FMT_LJ) && (b_ctrl.format != SAP_FMT_RJ);
    is_rj     = b_ctrl.format == SAP_FMT_RJ;
    wbits     = word_bits(b_ctrl.width);                                 // [RQ3]
    sbits     = slot_bits(b_ctrl.ratio);                                 // [RQ5]
    // right-justified words end on the slot's last edge
    off       = (is_rj && sbits > wbits) ? sbits - wbits : 6'h0;         // [RQ17]
    // standard format sees word select one edge late, so MSB lands on position 0
    ws_eff    = is_std ? ws_dly_reg : word_select_line;                  // [RQ13] [RQ15] [RQ1]
    ws_edge   = ws_eff != eff_prev_reg;                                  // [RQ7]
    pos_now   = ws_edge ? 6'h0 : ((pos_reg == 6'h3f) ? pos_reg : pos_reg + 6'h1);
    left_now  = is_std ? !ws_eff : ws_eff;                               // [RQ12] [RQ14] [RQ16]
    left_prev = is_std ? !eff_prev_reg : eff_prev_reg;
    in_win    = in_window(pos_now, off, wbits);                          // [RQ19]
  end

  // slot timing, all taken on rising edges
  always_ff @(posedge link_bclk or negedge brst_n) begin
    if (!brst_n) begin
      ws_dly_reg    <= 1'b0;
      eff_prev_reg  <= 1'b0;
      pos_reg       <= 6'h0;
      chan_left_reg <= 1'b1;
    end else begin
      ws_dly_reg    <= word_select_line;                                 // [RQ18]
      eff_prev_reg  <= ws_eff;
      pos_reg       <= pos_now;
      chan_left_reg <= left_now;
    end
  end

  // receive shift, MSB first, and per-slot word store
  always_ff @(posedge link_bclk or negedge brst_n) begin
    if (!brst_n) begin
      shift_reg   <= 32'h0;
      left_reg    <= 32'h0;
      right_reg   <= 32'h0;
      frm_tgl_reg <= 1'b0;
    end else begin
      if (ws_edge) begin
        if (left_prev) begin
          left_reg <= shift_reg << (SAP_BITS_32 - wbits);                // [RQ3]
        end else begin
          right_reg   <= shift_reg << (SAP_BITS_32 - wbits);
          frm_tgl_reg <= ~frm_tgl_reg;                                   // [RQ7]
        end
        shift_reg <= in_win ? {31'h0, serial_audio_in} : 32'h0;
      end else if (in_win) begin
        shift_reg <= {shift_reg[30:0], serial_audio_in};                 // [RQ2] [RQ19]
      end
    end
  end

  // transmit word handshake from the system side
  always_ff @(posedge link_bclk or negedge brst_n) begin
    if (!brst_n) begin
      req_s1_reg  <= 1'b0;
      req_s2_reg  <= 1'b0;
      ack_b_reg   <= 1'b0;
      tx_word_reg <= 32'h0;
    end else begin
      req_s1_reg <= tx_req_reg;
      req_s2_reg <= req_s1_reg;
      if (req_s2_reg != ack_b_reg) begin
        tx_word_reg <= tx_hold_reg;
        ack_b_reg   <= req_s2_reg;
      end
    end
  end

  // next bit period is predicted from the slot length, since the word select
  // for a justified MSB only arrives with the edge that samples it
  always_comb begin
    q_next       = ({1'b0, pos_reg} + 7'h01 >= {1'b0, sbits}) ? 6'h0 : pos_reg + 6'h1;
    ch_left_next = (q_next == 6'h0) ? !chan_left_reg : chan_left_reg;
    slot_match   = b_ocfg.slot ? !ch_left_next : ch_left_next;           // [RQ10]
    out_win      = in_window(q_next, off, wbits);
    tx_idx       = 6'h1f - (q_next - off);
  end

  // launch on the falling edge so the host captures on the next rising one
  always_ff @(negedge link_bclk or negedge brst_n) begin
    if (!brst_n) begin
      sao_reg    <= 1'b0;
      sao_oe_reg <= 1'b0;
    end else if (b_ocfg.enable && slot_match) begin                      // [RQ18]
      sao_oe_reg <= 1'b1;
      sao_reg    <= out_win ? tx_word_reg[tx_idx[4:0]] : 1'b0;           // [RQ19] [RQ2]
    end else begin
      sao_oe_reg <= !b_ocfg.highz;                                       // [RQ10] [RQ11]
      sao_reg    <= 1'b0;
    end
  end

  assign serial_audio_out    = sao_reg;
  assign serial_audio_out_oe = sao_oe_reg;

  // ---------------- checks ----------------
  sequence s_std_ws_change;
    is_std && (word_select_line != ws_dly_reg);
  endsequence

  sequence s_lj_ws_change;
    (b_ctrl.format == SAP_FMT_LJ) && (word_select_line != eff_prev_reg);
  endsequence

  sequence s_slot_start;
    (pos_reg == 6'h0) ##1 (pos_reg == 6'h1);
  endsequence

  a_std_msb_second: assert property (@(posedge link_bclk) disable iff (!brst_n) // [RQ13]
    s_std_ws_change |=> (ws_edge && pos_now == 6'h0))
    else $error("standard format slot did not start one edge after word select");

  a_lj_msb_first: assert property (@(posedge link_bclk) disable iff (!brst_n) // [RQ15]
    s_lj_ws_change ##0 $stable(b_ctrl) |=> s_slot_start)
    else $error("left-justified slot did not start on first edge");

  a_rj_lsb_end: assert property (@(posedge link_bclk) disable iff (!brst_n) // [RQ17]
    (is_rj && ws_edge && pos_reg == sbits - 6'h1 && wbits <= sbits)
      |-> (in_window(pos_reg, off, wbits) && !in_window(pos_reg + 6'h1, off, wbits)))
    else $error("right-justified word does not end on last slot edge");

  a_frame_store: assert property (@(posedge link_bclk) disable iff (!brst_n) // [RQ7]
    $changed(frm_tgl_reg) |-> ($past(ws_edge) && !$past(left_prev)))
    else $error("frame event outside end of right slot");

  a_idle_highz: assert property (@(posedge link_bclk) disable iff (!brst_n) // [RQ11]
    (!b_ocfg.enable && b_ocfg.highz && $past(brst_n)) |-> !serial_audio_out_oe)
    else $error("disabled output with high impedance select still driven");

  a_idle_zeros: assert property (@(posedge link_bclk) disable iff (!brst_n) // [RQ11]
    (!b_ocfg.enable && !b_ocfg.highz && $past(brst_n))
      |-> (serial_audio_out_oe && !serial_audio_out))
    else $error("disabled output without high impedance not driving zero");

  a_other_slot: assert property (@(posedge link_bclk) disable iff (!brst_n) // [RQ10]
    (b_ocfg.enable && $past(brst_n) && (ch_left_next == b_ocfg.slot))
      |-> (serial_audio_out_oe == !b_ocfg.highz) && !serial_audio_out)
    else $error("unused output slot not zero or high impedance");

  a_pad_zeros: assert property (@(posedge link_bclk) disable iff (!brst_n) // [RQ19]
    (b_ocfg.enable && $past(brst_n) && slot_match && !out_win)
      |-> (serial_audio_out_oe && !serial_audio_out))
    else $error("bit beyond word length not driven as zero");

  a_sample_pulse: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ7]
    new_frame |=> (audio_sample.valid ##1 !audio_sample.valid))
    else $error("frame did not give one sample pulse");

  a_left_pass: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ9]
    (new_frame && ctrl_reg.source_channel_select == SAP_CH_LEFT && !ctrl_reg.atten)
      |=> (audio_sample.data == $past(left_reg)))
    else $error("left source not passed unchanged");

  a_atten_half: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ8]
    (new_frame && ctrl_reg.source_channel_select == SAP_CH_RIGHT && ctrl_reg.atten)
      |=> (audio_sample.data == {$past(right_reg[31]), $past(right_reg[31:1])}))
    else $error("attenuated right source not halved");

  a_tx_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ10]
    (tx_req_reg != ack_s2_reg) |=> $stable(tx_hold_reg))
    else $error("transmit word changed during handoff");

endmodule // sap_top

/* File: testbench/sap_host_model.sv */
// partner model: host as bus master making bit clock, word select and serial data
module sap_host_model
  import sap_pkg::*;
(
  output logic      link_bclk,
  output logic      word_select_line,
  output logic      serial_audio_in,
  input  wire logic serial_audio_out,
  input  wire logic serial_audio_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] cap_raw [2];
  logic [1:0]  cap_oe  [2];
  initial begin
    link_bclk = 1'b0;
    word_select_line = 1'b1;
    serial_audio_in = 1'b0;
  end
  // clock stands still between runs; four lead-in edges hold the right-slot level
  task automatic run(input sap_format_t fmt, input int w, input int s,
                     input logic [31:0] l, input logic [31:0] r, input int n);
    logic lft;
    int   st;
    int   j;
    int   idx;
    logic [31:0] wd;
    lft = (fmt != SAP_FMT_STD);
    st = (fmt == SAP_FMT_STD) ? 1 : (fmt == SAP_FMT_LJ) ? 0 : s - w;
    for (int g = -4; g < 2 * s * n + 2; g++) begin
      j = (g - st + 4 * s) % (2 * s);
      idx = j % s;
      wd = (j < s) ? l : r;
      // bit clock and word select only ever come from here
      word_select_line = (g < 0 || (g / s) % 2) ? ~lft : lft;
      // bits past the word length carry junk the device must ignore
      serial_audio_in = (g >= 0 && idx < w) ? wd[31 - idx] : ~serial_audio_in;
      #15 link_bclk = 1'b1;
      if (g >= st && g - st < 2 * s * n) begin
        if (idx == 0) begin
          cap_raw[j / s] = '0;
          cap_oe[j / s] = {serial_audio_out_oe, serial_audio_out_oe};
        end
        cap_raw[j / s][31 - idx] = serial_audio_out;
        cap_oe[j / s] = {cap_oe[j / s][1] & serial_audio_out_oe,
                         cap_oe[j / s][0] | serial_audio_out_oe};
      end
      #15 link_bclk = 1'b0;
    end
  endtask
endmodule // sap_host_model

/* File: testbench/tb_top.sv */
// testbench: register access, frame traffic through the host model, self-checks
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_top;
  import sap_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic          sys_clk, resetn, reg_wr, reg_rd, bclk, ws, sdin, sdout, sdout_oe, drv;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, last_data, lm, rm, ex;
  logic [32:0]   sum;
  logic [3:0]    rate_code;
  sap_sample_t   audio_sample;
  sap_port_cfg_t c;
  sap_port_cfg_t pc [5];
  sap_out_cfg_t  oc [5];
  int            fail_count, total_checks, w, s;
  int            wtab [4] = '{16, 20, 24, 32};
  int            stab [3] = '{16, 24, 32};
  localparam logic [31:0] LW = 32'h1234_5678, RW = 32'h0abc_def0, TXD = 32'hc5a3_9f17;
  sap_top DUT (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_bclk(bclk), .word_select_line(ws), .serial_audio_in(sdin),
    .serial_audio_out(sdout), .serial_audio_out_oe(sdout_oe),
    .audio_sample(audio_sample), .sample_rate_code(rate_code));
  sap_host_model host (.link_bclk(bclk), .word_select_line(ws), .serial_audio_in(sdin),
    .serial_audio_out(sdout), .serial_audio_out_oe(sdout_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (audio_sample.valid === 1'b1) last_data <= audio_sample.data;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(nm, e, reg_rdata)
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // generous: the whole sequence needs well under a quarter of this
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
  initial begin
    resetn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    last_data = '0;
    fail_count = 0;
    total_checks = 0;
    pc[0] = '{SAP_CH_LEFT, 1'b0, SAP_RATIO_32, 4'h8, SAP_WIDTH_16, SAP_FMT_STD};
    pc[1] = '{SAP_CH_RIGHT, 1'b1, SAP_RATIO_48, 4'h8, SAP_WIDTH_24, SAP_FMT_LJ};
    pc[2] = '{SAP_CH_AVG, 1'b0, SAP_RATIO_64, 4'h8, SAP_WIDTH_20, SAP_FMT_RJ};
    pc[3] = '{SAP_CH_AVG, 1'b1, SAP_RATIO_64, 4'h8, SAP_WIDTH_32, SAP_FMT_LJ};
    pc[4] = '{SAP_CH_LEFT, 1'b0, SAP_RATIO_48, 4'h8, SAP_WIDTH_20, SAP_FMT_STD};
    oc[0] = '{1'b0, 1'b0, 1'b1};
    oc[1] = '{1'b1, 1'b1, 1'b1};
    oc[2] = '{1'b0, 1'b0, 1'b0};
    oc[3] = '{1'b1, 1'b0, 1'b0};
    oc[4] = '{1'b0, 1'b1, 1'b1};
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_chk(SAP_REG_CTRL, 32'(SAP_CTRL_RST), "ctrl reset");
    rd_chk(SAP_REG_OUTCFG, 32'h0, "outcfg reset");
    rd_chk(SAP_REG_STATUS, 32'h0, "status reset");
    rd_chk(8'h20, 32'h0, "unmapped");
    `CHK("rate reset", 4'h8, rate_code)
    for (int r = 0; r <= 9; r++) begin
      c = SAP_CTRL_RST;
      c.rate = 4'(r);
      wr(SAP_REG_CTRL, 32'(c));
      repeat (2) @(posedge sys_clk);
      `CHK("rate code", 4'(r), rate_code)
      rd_chk(SAP_REG_STATUS, (r > 8) ? 32'h4 : 32'h0, "rate status");
    end
    c = SAP_CTRL_RST;
    c.ratio = SAP_RATIO_32;
    c.width = SAP_WIDTH_24;
    wr(SAP_REG_CTRL, 32'(c));
    rd_chk(SAP_REG_STATUS, 32'h2, "ratio status");
    for (int k = 0; k < 5; k++) begin
      wr(SAP_REG_CTRL, 32'(pc[k]));
      wr(SAP_REG_OUTCFG, 32'(oc[k]));
      wr(SAP_REG_TXDATA, TXD);
      rd_chk(SAP_REG_STATUS, 32'h1, "tx busy");
      w = wtab[pc[k].width];
      s = stab[pc[k].ratio];
      lm = LW & ~(32'hffffffff >> w);
      rm = RW & ~(32'hffffffff >> w);
      sum = {lm[31], lm} + {rm[31], rm};
      ex = (pc[k].source_channel_select == SAP_CH_LEFT) ? lm : (pc[k].source_channel_select == SAP_CH_RIGHT) ? rm : sum[32:1];
      if (pc[k].atten) ex = {ex[31], ex[31:1]};
      host.run(pc[k].format, w, s, LW, RW, 4);
      repeat (10) @(posedge sys_clk);
      `CHK("sample", ex, last_data)
      rd_chk(SAP_REG_RXDATA, ex, "rx reg");
      for (int ch = 0; ch < 2; ch++) begin
        drv = oc[k].enable && (oc[k].slot == ch[0]);
        if (drv || !oc[k].highz)
          `CHK("out slot", drv ? (TXD & ~(32'hffffffff >> w)) : 32'h0, host.cap_raw[ch])
        if (pc[k].format == SAP_FMT_LJ)
          `CHK("out enable", (drv || !oc[k].highz) ? 2'h3 : 2'h0, host.cap_oe[ch])
      end
    end
    give_verdict;
  end
endmodule // tb_top
